// ==== hdl/ebrpm_pkg.sv ====
// package: constants for the external bus release and pin mux block
package ebrpm_pkg;
   // strobe and acknowledge are active low; idle level is high
   localparam logic STROBE_IDLE = 1'h1;
   localparam logic ACK_IDLE    = 1'h1;
   // reset value of the program address bit carried on the shared pin
   localparam logic ADDR18_RST  = 1'h0;
   // arbiter states, one-hot
   typedef enum logic [2:0] {
      ARB_OWN     = 3'h1,
      ARB_HOLD    = 3'h2,
      ARB_RESUME  = 3'h4
   } ebrpm_state_t;
endpackage

// ==== hdl/ebrpm_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ebrpm_sync (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // data
   input  wire logic din,
   output logic      dout
);
   logic stage1;
   logic next_stage1;
   logic next_dout;

   // reset holds the idle-high level of an active-low pin
   always_comb begin
      next_stage1 = din;
      next_dout   = stage1;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         stage1 <= 1'h1;
         dout   <= 1'h1;
      end else begin
         stage1 <= next_stage1;
         dout   <= next_dout;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/ebrpm_top.sv ====
// top: bus release handshake, io strobe and shared pin multiplexing
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - io strobe only for cpu external io
// - dma io space never reaches external pins
// - host-port mode: strobe pin becomes general pin 3
// - mode low: shared pin is subsystem select input
// - mode high: shared pin drives address bit 18
// - float low tristates strobe and shared pin
// - request honoured, then address data control float
// - ack only while held and floated
// - float low tristates the acknowledge too
// - combined emulation pin low floats outputs, clock
module ebrpm_top (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // pins from outside
   input  wire logic bus_release_req_n,
   input  wire logic emulation_float_pin,
   input  wire logic external_io_mode,
   input  wire logic host_mux_select,
   input  wire logic subsystem_select_in,
   // cpu side
   input  wire logic cpuIoAccess,
   input  wire logic dmaIoAccess,
   input  wire logic busCycleActive,
   input  wire logic cpuAddrBit18,
   input  wire logic general_pin_3,
   input  wire logic timer_output,
   input  wire logic timerOnPin3,
   input  wire logic clkOutLevel,
   // strobe pin
   output logic      io_space_strobe_n,
   output logic      strobeOe_b,
   // shared select / address bit 18 pin
   output logic      program_addr_bit18,
   output logic      sharedOe_b,
   output logic      subsystem_select,
   // bus release
   output logic      bus_release_ack_n,
   output logic      ackOe_b,
   output logic      busFloat,
   output logic      busGrantStall,
   // clock output
   output logic      clkOutPin,
   output logic      clkOutOe_b
);
   logic reqSync;
   logic floatSync;
   logic modeRaw;
   logic hostRaw;
   logic selRaw;
   logic settling;
   logic modeSync;
   logic selSync;

   ebrpm_sync uReq   (.ref_clk(ref_clk), .rst_b(rst_b), .din(bus_release_req_n),
                      .dout(reqSync));
   ebrpm_sync uFloat (.ref_clk(ref_clk), .rst_b(rst_b), .din(emulation_float_pin),
                      .dout(floatSync));
   ebrpm_sync uMode  (.ref_clk(ref_clk), .rst_b(rst_b), .din(external_io_mode),
                      .dout(modeRaw));
   ebrpm_sync uHost  (.ref_clk(ref_clk), .rst_b(rst_b), .din(host_mux_select),
                      .dout(hostRaw));
   ebrpm_sync uSel   (.ref_clk(ref_clk), .rst_b(rst_b), .din(subsystem_select_in),
                      .dout(selRaw));
   // a constant low through the same two flops marks the window in which
   // the active-high pins still show the reset flush level, not the pin
   ebrpm_sync uSettle (.ref_clk(ref_clk), .rst_b(rst_b), .din(1'h0),
                      .dout(settling));

   ebrpm_pkg::ebrpm_state_t state;
   ebrpm_pkg::ebrpm_state_t next_state;

   // active-high pins are masked until the flush is over, so the shared pin
   // is never driven against an outside select right after reset
   logic hostMode;
   logic floatAll;
   assign modeSync = modeRaw && !settling;
   assign selSync  = selRaw && !settling;
   assign hostMode = hostRaw && !settling;
   assign floatAll = !floatSync;

   // grant only between cycles, so an in-flight cycle always completes
   always_comb begin
      next_state = state;
      case (state)
         ebrpm_pkg::ARB_OWN: begin
            if (!reqSync && !busCycleActive) next_state = ebrpm_pkg::ARB_HOLD;
         end
         ebrpm_pkg::ARB_HOLD: begin
            if (reqSync) next_state = ebrpm_pkg::ARB_RESUME;
         end
         ebrpm_pkg::ARB_RESUME: begin
            // one owning cycle keeps a re-grant from overlapping the release
            next_state = ebrpm_pkg::ARB_OWN;
         end
         default: next_state = ebrpm_pkg::ARB_OWN;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) state <= ebrpm_pkg::ARB_OWN;
      else        state <= next_state;
   end

   // registered pin data
   logic next_strobe;
   logic next_addr18;
   logic next_sel;
   logic next_ack;
   logic next_clk;
   logic strobeReg;
   logic addrReg;
   logic selReg;
   logic ackReg;
   logic clkReg;

   always_comb begin
      // dma io space is internal only and never strobes the pin
      next_strobe = (cpuIoAccess && !dmaIoAccess) ? 1'h0 : ebrpm_pkg::STROBE_IDLE;
      if (hostMode) begin
         next_strobe = timerOnPin3 ? timer_output : general_pin_3;
      end
      next_addr18 = modeSync ? cpuAddrBit18 : ebrpm_pkg::ADDR18_RST;
      next_sel    = modeSync ? 1'h0 : selSync;
      next_ack    = (next_state == ebrpm_pkg::ARB_HOLD) ? 1'h0
                                                        : ebrpm_pkg::ACK_IDLE;
      // clock level is only retimed here; stopping it is the clock block's job
      next_clk    = clkOutLevel;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         strobeReg <= ebrpm_pkg::STROBE_IDLE;
         addrReg   <= ebrpm_pkg::ADDR18_RST;
         selReg    <= 1'h0;
         ackReg    <= ebrpm_pkg::ACK_IDLE;
         clkReg    <= 1'h0;
      end else begin
         strobeReg <= next_strobe;
         addrReg   <= next_addr18;
         selReg    <= next_sel;
         ackReg    <= next_ack;
         clkReg    <= next_clk;
      end
   end

   // bus floats a cycle ahead of the ack so ack never precedes the float
   logic inHold;
   assign inHold = (state == ebrpm_pkg::ARB_HOLD);
   assign busFloat      = inHold || (next_state == ebrpm_pkg::ARB_HOLD) || floatAll;
   // a pending request stops new cycles, so the grant is never starved
   assign busGrantStall = (state != ebrpm_pkg::ARB_OWN) || !reqSync;
   assign io_space_strobe_n  = strobeReg;
   // in hold the strobe and the shared address pin count as bus lines
   assign strobeOe_b         = floatAll || inHold;
   assign program_addr_bit18 = addrReg;
   assign sharedOe_b         = floatAll || !modeSync || inHold;
   assign subsystem_select   = selReg;
   assign bus_release_ack_n  = ackReg;
   assign ackOe_b            = floatAll;
   assign clkOutPin          = clkReg;
   assign clkOutOe_b         = floatAll;

   // checks
   ack_needs_float_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !bus_release_ack_n |-> busFloat) else $error("ack without float");
   ack_in_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (bus_release_ack_n == 1'h0) == inHold) else $error("ack mismatch hold");
   float_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      floatAll |-> ackOe_b && strobeOe_b && sharedOe_b && clkOutOe_b)
      else $error("outputs not floated");
   float_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !floatAll |-> !ackOe_b && !clkOutOe_b) else $error("ack floated without float pin");
   cycle_finish_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (state == ebrpm_pkg::ARB_OWN && busCycleActive) |=> state != ebrpm_pkg::ARB_HOLD)
      else $error("granted mid cycle");
   release_resume_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (inHold && reqSync) |=> state == ebrpm_pkg::ARB_RESUME ##1 state == ebrpm_pkg::ARB_OWN)
      else $error("no resume");
   dma_no_strobe_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (dmaIoAccess && !hostMode) |=> io_space_strobe_n) else $error("dma strobed");
   cpu_strobe_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (cpuIoAccess && !dmaIoAccess && !hostMode) |=> !io_space_strobe_n)
      else $error("cpu strobe missing");
   shared_dir_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !modeSync |-> sharedOe_b) else $error("shared pin driven as input");
   sel_input_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !modeSync |=> subsystem_select == $past(selSync)) else $error("select not passed");
   addr_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      modeSync |=> program_addr_bit18 == $past(cpuAddrBit18)) else $error("addr18 wrong");
   shared_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (modeSync && !inHold && !floatAll) |-> !sharedOe_b) else $error("addr18 not driven");
   sel_mode_high_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      modeSync |=> !subsystem_select) else $error("select seen in address mode");
   pin3_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (hostMode && !timerOnPin3) |=> io_space_strobe_n == $past(general_pin_3))
      else $error("pin3 wrong");
   timer_pin3_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (hostMode && timerOnPin3) |=> io_space_strobe_n == $past(timer_output))
      else $error("timer not on pin3");
   grant_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (state == ebrpm_pkg::ARB_OWN && !reqSync && !busCycleActive) |->
      busFloat ##1 (inHold && !bus_release_ack_n)) else $error("request not granted");
   hold_lines_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      inHold |-> busFloat && strobeOe_b && sharedOe_b) else $error("lines driven in hold");
   hold_stands_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (inHold && !reqSync) |=> inHold && !bus_release_ack_n) else $error("hold dropped");

   // covers
   grant_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
      state == ebrpm_pkg::ARB_OWN ##1 inHold ##[1:20] state == ebrpm_pkg::ARB_RESUME);
   float_c: cover property (@(posedge ref_clk) disable iff (!rst_b) floatAll ##1 !floatAll);
   strobe_c: cover property (@(posedge ref_clk) disable iff (!rst_b) !io_space_strobe_n);
   addr_c: cover property (@(posedge ref_clk) disable iff (!rst_b) !sharedOe_b);
   timer_c: cover property (@(posedge ref_clk) disable iff (!rst_b) hostMode && timerOnPin3);
endmodule
`default_nettype wire

// ==== tb/ebrpm_master.sv ====
// partner model: outside master asking for the bus
`timescale 1ns/1ps
`default_nettype none
module ebrpm_master (
   // clock
   input  wire logic       ref_clk,
   // control from bench
   input  wire logic       go,
   input  wire logic [3:0] holdLen,
   // bus release handshake
   input  wire logic       bus_release_ack_n,
   output logic            bus_release_req_n,
   output logic            busDrive,
   output logic            granted
);
   // one process owns every output, so each has a single driver
   initial begin
      bus_release_req_n = 1'h1;
      busDrive = 1'h0;
      granted = 1'h0;
      forever begin
         @(posedge ref_clk);
         if (go && bus_release_req_n) begin
            bus_release_req_n <= 1'h0;
            // a stalled grant is waited out, but not for ever
            for (int i = 0; i < 40 && bus_release_ack_n !== 1'h0; i++) @(posedge ref_clk);
            // the lines are touched only once the ack is seen
            if (bus_release_ack_n === 1'h0) begin
               granted <= 1'h1;
               busDrive <= 1'h1;
               repeat (holdLen) @(posedge ref_clk);
               busDrive <= 1'h0;
               granted <= 1'h0;
            end
            bus_release_req_n <= 1'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/ebrpm_test.sv ====
// self-checking bench for the bus release and pin mux block
`timescale 1ns/1ps
`default_nettype none
module ebrpm_test;
   logic ref_clk = 1'h0, rst_b = 1'h0, emulation_float_pin = 1'h1, external_io_mode = 1'h0;
   logic host_mux_select = 1'h0, subsystem_select_in = 1'h0, cpuIoAccess = 1'h0;
   logic dmaIoAccess = 1'h0, busCycleActive = 1'h0, cpuAddrBit18 = 1'h0, go = 1'h0;
   logic general_pin_3 = 1'h0, timer_output = 1'h0, timerOnPin3 = 1'h0, clkOutLevel = 1'h0;
   logic bus_release_req_n, io_space_strobe_n, strobeOe_b, program_addr_bit18, sharedOe_b;
   logic subsystem_select, bus_release_ack_n, ackOe_b, busFloat, busGrantStall;
   logic clkOutPin, clkOutOe_b, busDrive, granted;
   logic [3:0] holdLen = 4'h3;
   logic [4:0] q[$];
   int error_cnt = 0, num_checks = 0;
   event look;
   string pinName [12] = '{"clkOutPin", "io_space_strobe_n", "strobeOe_b",
      "program_addr_bit18", "sharedOe_b", "subsystem_select", "bus_release_ack_n",
      "ackOe_b", "busFloat", "clkOutOe_b", "busGrantStall", "busDrive"};
   always #20 ref_clk = ~ref_clk;
   ebrpm_top u_ebrpm_top (.ref_clk, .rst_b, .bus_release_req_n, .emulation_float_pin,
      .external_io_mode, .host_mux_select, .subsystem_select_in, .cpuIoAccess, .dmaIoAccess,
      .busCycleActive, .cpuAddrBit18, .general_pin_3, .timer_output, .timerOnPin3,
      .clkOutLevel, .io_space_strobe_n, .strobeOe_b, .program_addr_bit18, .sharedOe_b,
      .subsystem_select, .bus_release_ack_n, .ackOe_b, .busFloat, .busGrantStall,
      .clkOutPin, .clkOutOe_b);
   ebrpm_master u_ebrpm_master (.ref_clk, .go, .holdLen, .bus_release_ack_n,
      .bus_release_req_n, .busDrive, .granted);
   function automatic logic seen(input logic [3:0] s);
      logic [11:0] v;
      v = {busDrive, busGrantStall, clkOutOe_b, busFloat, ackOe_b, bus_release_ack_n,
         subsystem_select, sharedOe_b, program_addr_bit18, strobeOe_b, io_space_strobe_n,
         clkOutPin};
      return v[s];
   endfunction
   task automatic note(input logic [3:0] s, input logic e);
      q.push_back({s, e});
   endtask
   task automatic chk(input logic [3:0] s, input logic e);
      num_checks++;
      if (seen(s) !== e) begin
         error_cnt++;
         $display("mismatch %s expected %b seen %b", pinName[s], e, seen(s));
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial forever begin
      logic [4:0] n;
      @(look);
      while (q.size() > 0) begin
         n = q.pop_front();
         chk(n[4:1], n[0]);
      end
   end
   initial begin
      #100us;
      error_cnt++;
      report_and_stop;
   end
   initial begin
      void'($urandom(32'h7d81c6bd));
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'h1;
      for (int i = 0; i < 6; i++) begin
         @(posedge ref_clk);
         cpuIoAccess <= 1'h1;
         dmaIoAccess <= i[0];
         @(posedge ref_clk);
         cpuIoAccess <= 1'h0;
         #1 note(1, i[0]);
         -> look;
      end
      for (int i = 0; i < 8; i++) begin
         @(posedge ref_clk);
         external_io_mode <= i[0];
         host_mux_select <= i[1];
         timerOnPin3 <= i[2];
         {cpuAddrBit18, subsystem_select_in, clkOutLevel} <= 3'($urandom);
         {general_pin_3, timer_output} <= 2'($urandom);
         repeat (5) @(posedge ref_clk);
         #1 note(4, ~external_io_mode);
         note(5, subsystem_select_in & ~external_io_mode);
         if (external_io_mode) note(3, cpuAddrBit18);
         if (host_mux_select) note(1, timerOnPin3 ? timer_output : general_pin_3);
         note(0, clkOutLevel);
         note(10, 1'h0);
         -> look;
      end
      @(posedge ref_clk);
      host_mux_select <= 1'h0;
      busCycleActive <= 1'h1;
      go <= 1'h1;
      @(posedge ref_clk);
      go <= 1'h0;
      // a bus cycle in flight holds the grant back
      repeat (8) @(posedge ref_clk);
      #1 note(6, 1'h1);
      note(8, 1'h0);
      note(10, 1'h1);
      note(11, 1'h0);
      -> look;
      @(posedge ref_clk);
      busCycleActive <= 1'h0;
      for (int i = 0; i < 20 && !granted; i++) @(posedge ref_clk);
      #1 note(6, 1'h0);
      note(8, 1'h1);
      note(10, 1'h1);
      note(11, 1'h1);
      note(2, 1'h1);
      note(4, 1'h1);
      -> look;
      for (int i = 0; i < 20 && granted; i++) @(posedge ref_clk);
      repeat (6) @(posedge ref_clk);
      #1 note(6, 1'h1);
      note(8, 1'h0);
      note(10, 1'h0);
      note(11, 1'h0);
      note(4, 1'h0);
      -> look;
      @(posedge ref_clk);
      emulation_float_pin <= 1'h0;
      repeat (4) @(posedge ref_clk);
      #1 note(2, 1'h1);
      note(4, 1'h1);
      note(7, 1'h1);
      note(9, 1'h1);
      -> look;
      repeat (2) @(posedge ref_clk);
      report_and_stop;
   end
endmodule
`default_nettype wire
